// File: adc_sync_ref_pattern_config.v
// sync, reference, clock input and test pattern configuration registers
`timescale 1ns/1ns
`default_nettype none
`include "adc_cfg_defines.vh"

module adc_sync_ref_pattern_config (
   input  wire        clk,                   // 50 MHz system clock
   input  wire        reset_n,               // asynchronous reset, active low
   input  wire        sen_n,                 // serial frame select, active low
   input  wire        sclk,                  // serial clock
   input  wire        sdata_in,              // serial data in
   input  wire        sync_powerdown_pin,    // combined sync / power down pin
   input  wire        reference_buffer_pin,  // reference option pin
   output wire        sdout,                 // serial read data
   output reg         global_powerdown,      // global power down level
   output reg         sync_pulse,            // one-cycle sync command
   output reg         reference_by_pin,      // reference chosen by pin
   output reg         reference_internal,    // internal reference
   output reg         reference_ext_buffered,// external ref through buffer
   output reg         reference_ext_direct,  // external ref direct
   output reg         clock_single_ended,    // single-ended clock input
   output reg         diff_clock_powerdown,  // differential clock buffer off
   output reg         single_ended_input,    // single-ended analog input
   output reg         bit_map_load,          // one-cycle bit-map reload
   output reg  [17:0] custom_pattern_value,  // custom pattern / ramp step
   output reg  [2:0]  test_pattern_mode,     // raw test pattern mode
   output reg         pattern_normal,        // normal data output
   output reg         pattern_ramp,          // ramp pattern output
   output reg         pattern_constant       // constant pattern output
);

   //---------------------------------------------------------------------------
   // register storage
   //---------------------------------------------------------------------------
   reg [7:0] sync_reference_clock_control; // sync, reference, clock
   reg       single_ended_input_select;    // analog input type bit
   reg       bit_map_load_strobe;          // load strobe bit
   reg [7:0] custom_pattern_low;           // pattern bits 7:0
   reg [7:0] custom_pattern_mid;           // pattern bits 15:8
   reg [4:0] custom_pattern_high_test_mode;// mode and pattern bits 17:16

   reg       strobe_prev;   // strobe value one cycle ago
   reg       trigger_prev;  // soft trigger value one cycle ago
   reg       pin_prev;      // sync pin level one cycle ago

   wire       wr_en;    // write strobe from serial port
   wire [6:0] addr;     // addressed register
   wire [7:0] wr_data;  // write byte
   reg  [7:0] rd_data;  // read byte for serial port

   //---------------------------------------------------------------------------
   // serial configuration port
   //---------------------------------------------------------------------------
   serial_config_port serial_config_port_inst (
      .clk      (clk),
      .reset_n  (reset_n),
      .sen_n    (sen_n),
      .sclk     (sclk),
      .sdata_in (sdata_in),
      .rd_data  (rd_data),
      .sdout    (sdout),
      .wr_en    (wr_en),
      .addr     (addr),
      .wr_data  (wr_data)
   );

   //---------------------------------------------------------------------------
   // decoding helpers
   //---------------------------------------------------------------------------
   // register index: 0 none, 1..6 the mapped registers
   function [2:0] reg_index;
      input [6:0] a;
      begin
         case (a)
            `ADDR_SYNC_REF_CLK: reg_index = 3'h1;
            `ADDR_ANALOG_INPUT: reg_index = 3'h2;
            `ADDR_BIT_MAP_LOAD: reg_index = 3'h3;
            `ADDR_PATTERN_LOW:  reg_index = 3'h4;
            `ADDR_PATTERN_MID:  reg_index = 3'h5;
            `ADDR_PATTERN_HIGH: reg_index = 3'h6;
            default:            reg_index = 3'h0;
         endcase
      end
   endfunction

   // one-hot reference decode; code 11 selects nothing
   function [2:0] ref_decode;
      input [1:0] code;
      begin
         case (code)
            `REF_INTERNAL:     ref_decode = 3'h1;
            `REF_EXT_BUFFERED: ref_decode = 3'h2;
            `REF_EXT_DIRECT:   ref_decode = 3'h4;
            default:           ref_decode = 3'h0;
         endcase
      end
   endfunction

   // one-hot test pattern decode; unused codes select nothing
   function [2:0] mode_decode;
      input [2:0] code;
      begin
         case (code)
            `MODE_NORMAL:   mode_decode = 3'h1;
            `MODE_RAMP:     mode_decode = 3'h2;
            `MODE_CONSTANT: mode_decode = 3'h4;
            default:        mode_decode = 3'h0;
         endcase
      end
   endfunction

   //---------------------------------------------------------------------------
   // derived events
   //---------------------------------------------------------------------------
   wire reference_control_source   = sync_reference_clock_control[`BIT_REFERENCE_CONTROL_SOURCE_SOURCE];
   wire soft_en   = sync_reference_clock_control[`BIT_SOFT_SYNC_EN];
   wire pin_func  = sync_reference_clock_control[`BIT_SYNC_PIN_FUNC];
   wire trigger   = sync_reference_clock_control[`BIT_SOFT_SYNC_TRIG];
   wire [1:0] ref_sel = sync_reference_clock_control[`BIT_REF_SEL_HI:`BIT_REF_SEL_LO];

   // the load fires when the strobe is written back to 0 after a 1
   wire load_fire = strobe_prev & ~bit_map_load_strobe; // [R8] [R9]

   // only the rising edge of the held trigger counts, and only when enabled
   wire soft_sync = trigger & ~trigger_prev & soft_en; // [R2] [R13]

   // the pin syncs only in sync function and while the register path is off
   wire pin_sync = sync_powerdown_pin & ~pin_prev & pin_func & ~soft_en; // [R1] [R3]

   //---------------------------------------------------------------------------
   // register writes and bit-map load
   //---------------------------------------------------------------------------
   // a load clears all other config registers; a write in the same cycle
   // cannot occur, since a frame is sixteen serial clocks long, but the
   // write is placed last so it would win anyway
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_reference_clock_control  <= `RESET_BYTE;
         single_ended_input_select     <= 1'b0;
         bit_map_load_strobe           <= 1'b0;
         custom_pattern_low            <= `RESET_BYTE;
         custom_pattern_mid            <= `RESET_BYTE;
         custom_pattern_high_test_mode <= 5'h00;
      end else begin
         if (load_fire) begin
            // loading the bit map discards earlier configuration
            sync_reference_clock_control  <= `RESET_BYTE; // [R9]
            single_ended_input_select     <= 1'b0;
            custom_pattern_low            <= `RESET_BYTE;
            custom_pattern_mid            <= `RESET_BYTE;
            custom_pattern_high_test_mode <= 5'h00;
         end
         if (wr_en) begin
            case (reg_index(addr))
               3'h1: begin
                  // reserved bit 4 is not stored; the trigger is held as written
                  sync_reference_clock_control <= wr_data & 8'hef; // [R2]
               end
               3'h2: begin
                  single_ended_input_select <= wr_data[`BIT_SE_INPUT]; // [R7]
               end
               3'h3: begin
                  bit_map_load_strobe <= wr_data[`BIT_MAP_STROBE]; // [R8]
               end
               3'h4: begin
                  custom_pattern_low <= wr_data; // [R10]
               end
               3'h5: begin
                  custom_pattern_mid <= wr_data; // [R10]
               end
               3'h6: begin
                  custom_pattern_high_test_mode <= wr_data[4:0]; // [R10]
               end
               default: begin
                  // unmapped address: write ignored
               end
            endcase
         end
      end
   end

   //---------------------------------------------------------------------------
   // read multiplexer
   //---------------------------------------------------------------------------
   // reserved bits read as zero, unmapped addresses read zero
   always @* begin
      case (reg_index(addr))
         3'h1:    rd_data = sync_reference_clock_control;
         3'h2:    rd_data = {2'h0, single_ended_input_select, 5'h00};
         3'h3:    rd_data = {7'h00, bit_map_load_strobe};
         3'h4:    rd_data = custom_pattern_low;
         3'h5:    rd_data = custom_pattern_mid;
         3'h6:    rd_data = {3'h0, custom_pattern_high_test_mode};
         default: rd_data = 8'h00;
      endcase
   end

   //---------------------------------------------------------------------------
   // edge history
   //---------------------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strobe_prev  <= 1'b0;
         trigger_prev <= 1'b0;
         pin_prev     <= 1'b0;
      end else begin
         strobe_prev  <= bit_map_load_strobe;
         trigger_prev <= trigger; // [R13]
         pin_prev     <= sync_powerdown_pin;
      end
   end

   //---------------------------------------------------------------------------
   // registered control outputs
   //---------------------------------------------------------------------------
   // every output is a flop, so each follows its cause by one clock
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         global_powerdown       <= 1'b0;
         sync_pulse             <= 1'b0;
         reference_by_pin       <= 1'b1;
         reference_internal     <= 1'b0;
         reference_ext_buffered <= 1'b0;
         reference_ext_direct   <= 1'b0;
         clock_single_ended     <= 1'b0;
         diff_clock_powerdown   <= 1'b0;
         single_ended_input     <= 1'b0;
         bit_map_load           <= 1'b0;
         custom_pattern_value   <= 18'h0_0000;
         test_pattern_mode      <= 3'h0;
         pattern_normal         <= 1'b1;
         pattern_ramp           <= 1'b0;
         pattern_constant       <= 1'b0;
      end else begin
         // pin high means power down unless the pin is set to sync
         global_powerdown <= sync_powerdown_pin & ~pin_func; // [R1]
         sync_pulse       <= soft_sync | pin_sync; // [R1] [R2] [R3]

         // reference and clock style follow the register only under
         // register control; otherwise the pin decides the reference
         reference_by_pin <= ~reference_control_source; // [R4]
         {reference_ext_direct, reference_ext_buffered, reference_internal}
            <= reference_control_source ? ref_decode(ref_sel) : 3'h0; // [R5]
         clock_single_ended   <= reference_control_source
                                 & sync_reference_clock_control[`BIT_SE_CLOCK]; // [R6]
         diff_clock_powerdown <= reference_control_source
                                 & sync_reference_clock_control[`BIT_SE_CLOCK]; // [R6]

         single_ended_input <= single_ended_input_select; // [R7]
         bit_map_load       <= load_fire; // [R8]

         custom_pattern_value <= {custom_pattern_high_test_mode[`BIT_PATTERN_TOP_HI:0],
                                  custom_pattern_mid, custom_pattern_low}; // [R10]
         test_pattern_mode <=
            custom_pattern_high_test_mode[`BIT_TEST_MODE_HI:`BIT_TEST_MODE_LO]; // [R10]
         {pattern_constant, pattern_ramp, pattern_normal} <= mode_decode(
            custom_pattern_high_test_mode[`BIT_TEST_MODE_HI:`BIT_TEST_MODE_LO]); // [R11]
      end
   end

   // the reference pin level is passed on unchanged by the analog side;
   // it is only tied to an unused wire here and reaches no output or read data
   wire unused_reference_buffer_pin = reference_buffer_pin;

endmodule
`default_nettype wire

// File: adc_cfg_defines.vh
// register offsets, field positions, reset values and frame layout of the config slice
//------------------------------------------------------------------------------
// Contract
// [R1] pin bit picks power down or sync
// [R2] trigger bit syncs when enabled, never self-clears
// [R3] soft sync enable moves sync to register
// [R4] source bit: pin or register picks reference
// [R5] reference code 00 int, 01 buffered, 10 direct
// [R6] single-ended clock kills differential clock buffer
// [R7] analog bit five selects single-ended input
// [R8] host pulses load strobe after interface write
// [R9] bit-map load clears earlier configuration writes
// [R10] pattern bytes low, mid, then high bits
// [R11] mode 000 normal, 010 ramp, 011 constant
// [R12] host programs ramp step 10000 for 14 bits
// [R13] trigger rising edge gives one sync pulse
// [R14] host writes zero reserved, clears trigger first
//------------------------------------------------------------------------------
`ifndef ADC_CFG_DEFINES_VH
`define ADC_CFG_DEFINES_VH

// register addresses (seven-bit serial address field)
`define ADDR_SYNC_REF_CLK    7'h0e
`define ADDR_ANALOG_INPUT    7'h11
`define ADDR_BIT_MAP_LOAD    7'h13
`define ADDR_PATTERN_LOW     7'h14
`define ADDR_PATTERN_MID     7'h15
`define ADDR_PATTERN_HIGH    7'h16

// fields of the sync / reference / clock register
`define BIT_SYNC_PIN_FUNC    7
`define BIT_SOFT_SYNC_TRIG   6
`define BIT_SOFT_SYNC_EN     5
`define BIT_REFERENCE_CONTROL_SOURCE_SOURCE   3
`define BIT_REF_SEL_HI       2
`define BIT_REF_SEL_LO       1
`define BIT_SE_CLOCK         0

// other fields
`define BIT_SE_INPUT         5
`define BIT_MAP_STROBE       0
`define BIT_TEST_MODE_HI     4
`define BIT_TEST_MODE_LO     2
`define BIT_PATTERN_TOP_HI   1

// reset values
`define RESET_BYTE           8'h00

// reference select codes
`define REF_INTERNAL         2'h0
`define REF_EXT_BUFFERED     2'h1
`define REF_EXT_DIRECT       2'h2

// test pattern mode codes
`define MODE_NORMAL          3'h0
`define MODE_RAMP            3'h2
`define MODE_CONSTANT        3'h3

// serial frame: read flag, seven address bits, eight data bits
`define FRAME_BITS           16
`define ADDR_DONE_COUNT      5'h07
`define DATA_START_COUNT     5'h08
`define FRAME_LAST_COUNT     5'h0f

`endif

// File: serial_config_port.v
// serial configuration port: frames in writes, shifts out read data
`timescale 1ns/1ns
`default_nettype none
`include "adc_cfg_defines.vh"

module serial_config_port (
   input  wire       clk,      // system clock
   input  wire       reset_n,  // asynchronous reset, active low
   input  wire       sen_n,    // frame select, active low
   input  wire       sclk,     // serial clock, sampled by clk
   input  wire       sdata_in, // serial data from host
   input  wire [7:0] rd_data,  // byte at the addressed register
   output reg        sdout,    // serial read data to host
   output reg        wr_en,    // one-cycle write strobe
   output reg  [6:0] addr,     // register address of frame
   output reg  [7:0] wr_data   // byte to write
);

   reg       sclk_prev; // last sampled serial clock
   reg [4:0] bit_cnt;   // bits taken this frame
   reg [6:0] shift_in;  // incoming bits so far
   reg [7:0] shift_out; // remaining read bits
   reg       rd_mode;   // frame is a read

   wire sclk_rise = ~sen_n & sclk & ~sclk_prev;
   wire sclk_fall = ~sen_n & ~sclk & sclk_prev;

   //---------------------------------------------------------------------------
   // frame sequencer
   //---------------------------------------------------------------------------
   // the serial clock is oversampled, so it must run well below clk / 4
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_prev <= 1'b0;
         bit_cnt   <= 5'h00;
         shift_in  <= 7'h00;
         shift_out <= 8'h00;
         rd_mode   <= 1'b0;
         sdout     <= 1'b0;
         wr_en     <= 1'b0;
         addr      <= 7'h00;
         wr_data   <= 8'h00;
      end else begin
         sclk_prev <= sclk;
         wr_en     <= 1'b0;
         if (sen_n) begin
            // idle between frames: restart the count
            bit_cnt <= 5'h00;
            rd_mode <= 1'b0;
            sdout   <= 1'b0;
         end else if (sclk_rise && bit_cnt < `FRAME_BITS) begin
            shift_in <= {shift_in[5:0], sdata_in};
            bit_cnt  <= bit_cnt + 5'h01;
            if (bit_cnt == `ADDR_DONE_COUNT) begin
               // header complete: flag plus address
               addr    <= {shift_in[5:0], sdata_in};
               rd_mode <= shift_in[6];
            end
            if (bit_cnt == `FRAME_LAST_COUNT && !rd_mode) begin
               wr_data <= {shift_in[6:0], sdata_in};
               wr_en   <= 1'b1;
            end
         end else if (sclk_fall && rd_mode) begin
            if (bit_cnt == `DATA_START_COUNT) begin
               // address is settled by now, so load the read byte
               sdout     <= rd_data[7];
               shift_out <= {rd_data[6:0], 1'b0};
            end else begin
               sdout     <= shift_out[7];
               shift_out <= {shift_out[6:0], 1'b0};
            end
         end
      end
   end

endmodule
`default_nettype wire

// File: adc_sync_ref_pattern_config_assertions.sv
// checker for the sync, reference and test pattern configuration outputs
`timescale 1ns/1ns
`default_nettype none
module adc_sync_ref_pattern_config_assertions (
   input wire logic        clk,                    // system clock
   input wire logic        reset_n,                // reset, active low
   input wire logic        sync_powerdown_pin,     // combined pin
   input wire logic        global_powerdown,       // power down level
   input wire logic        sync_pulse,             // sync command
   input wire logic        reference_by_pin,       // pin owns reference
   input wire logic        reference_internal,     // internal reference
   input wire logic        reference_ext_buffered, // buffered external
   input wire logic        reference_ext_direct,   // direct external
   input wire logic        clock_single_ended,     // single-ended clock
   input wire logic        diff_clock_powerdown,   // diff buffer off
   input wire logic        single_ended_input,     // single-ended input
   input wire logic        bit_map_load,           // reload pulse
   input wire logic [17:0] custom_pattern_value,   // pattern value
   input wire logic [2:0]  test_pattern_mode,      // raw mode field
   input wire logic        pattern_normal,         // normal output
   input wire logic        pattern_ramp,           // ramp output
   input wire logic        pattern_constant        // constant output
);
   //-------------------------------------------------------------
   // properties, all in the one clock domain
   //-------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // a low pin can never leave the part powered down a cycle later
   property p_pd_off; !sync_powerdown_pin |=> !global_powerdown; endproperty
   a_pd_off: assert property (p_pd_off) else $error("power down with pin low");
   property p_pd_src; global_powerdown |-> $past(sync_powerdown_pin); endproperty
   a_pd_src: assert property (p_pd_src) else $error("power down without cause");
   // held trigger level must not resync again and again
   property p_sync_one; sync_pulse |=> !sync_pulse; endproperty
   a_sync_one: assert property (p_sync_one) else $error("sync pulse too long");
   property p_load_one; bit_map_load |=> !bit_map_load; endproperty
   a_load_one: assert property (p_load_one) else $error("load pulse too long");
   // after a reload every covered field shows its reset value
   property p_load_clr;
      bit_map_load |=> !single_ended_input && custom_pattern_value == 18'h0_0000
         && test_pattern_mode == 3'h0 && reference_by_pin && !clock_single_ended;
   endproperty
   a_load_clr: assert property (p_load_clr) else $error("reload left fields set");
   property p_ref_hot;
      $onehot0({reference_internal, reference_ext_buffered, reference_ext_direct});
   endproperty
   a_ref_hot: assert property (p_ref_hot) else $error("reference not one-hot");
   property p_ref_pin;
      reference_by_pin |-> !(reference_internal || reference_ext_buffered
         || reference_ext_direct || clock_single_ended);
   endproperty
   a_ref_pin: assert property (p_ref_pin) else $error("register ref under pin");
   property p_clk_pair; clock_single_ended == diff_clock_powerdown; endproperty
   a_clk_pair: assert property (p_clk_pair) else $error("clock buffer mismatch");
   property p_mode_dec;
      pattern_normal == (test_pattern_mode == 3'h0) && pattern_ramp ==
         (test_pattern_mode == 3'h2) && pattern_constant == (test_pattern_mode == 3'h3);
   endproperty
   a_mode_dec: assert property (p_mode_dec) else $error("pattern decode wrong");

   c_sync: cover property (sync_pulse);
   c_load: cover property (bit_map_load);
   c_pd:   cover property (global_powerdown);
   c_ramp: cover property (pattern_ramp);
endmodule
`default_nettype wire

// File: serial_host_model.sv
// host model that frames register writes and reads on the serial port
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
   input  wire logic clk,      // system clock
   input  wire logic sdout,    // read data from device
   output var  logic sen_n,    // frame select, active low
   output var  logic sclk,     // serial clock, still outside frames
   output var  logic sdata_in  // serial data to device
);
   initial begin
      sen_n = 1'b1;
      sclk = 1'b0;
      sdata_in = 1'b0;
   end

   //-------------------------------------------------------------
   // one frame: read flag, seven address bits, eight data bits
   //-------------------------------------------------------------
   // each sclk phase lasts three clocks
   task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
      logic [15:0] bits;
      bits = {rd, a, d};
      q = 8'h00;
      @(posedge clk);
      sen_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge clk);
         sdata_in <= bits[i];
         sclk <= 1'b0;
         repeat (3) @(posedge clk);
         sclk <= 1'b1;
         if (i < 8) begin
            q[i] = sdout; // read bits are taken on the rise
         end
         repeat (2) @(posedge clk);
      end
      @(posedge clk);
      sen_n <= 1'b1;
      sclk <= 1'b0;
      sdata_in <= ~sdata_in; // released line flips
      repeat (6) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// File: adc_sync_ref_pattern_config_test.sv
// self-checking bench for the sync, reference and pattern configuration slice
`timescale 1ns/1ns
`default_nettype none
module adc_sync_ref_pattern_config_test;
   logic clk, reset_n, pin, ref_pin;  // clock, reset and device pins
   wire  sen_n, sclk, sdata_in, sdout; // serial port
   wire  gpd, sync_pulse, by_pin, r_int, r_buf, r_dir, cse, dpd, sei, load;
   wire  p_norm, p_ramp, p_const;     // pattern decode
   wire [17:0] pat;                   // custom pattern value
   wire [2:0]  mode;                  // test pattern mode
   int err_total, check_count, sync_seen, load_seen;
   logic [6:0] addrs [6] = '{7'h0e, 7'h11, 7'h13, 7'h14, 7'h15, 7'h16};

   adc_sync_ref_pattern_config adc_sync_ref_pattern_config_inst (
      .clk(clk), .reset_n(reset_n), .sen_n(sen_n), .sclk(sclk), .sdata_in(sdata_in),
      .sync_powerdown_pin(pin), .reference_buffer_pin(ref_pin), .sdout(sdout),
      .global_powerdown(gpd), .sync_pulse(sync_pulse), .reference_by_pin(by_pin),
      .reference_internal(r_int), .reference_ext_buffered(r_buf),
      .reference_ext_direct(r_dir), .clock_single_ended(cse), .diff_clock_powerdown(dpd),
      .single_ended_input(sei), .bit_map_load(load), .custom_pattern_value(pat),
      .test_pattern_mode(mode), .pattern_normal(p_norm), .pattern_ramp(p_ramp),
      .pattern_constant(p_const));
   serial_host_model serial_host_model_inst (
      .clk(clk), .sdout(sdout), .sen_n(sen_n), .sclk(sclk), .sdata_in(sdata_in));

   //-------------------------------------------------------------
   // clock, pulse counters, watchdog
   //-------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (sync_pulse === 1'b1) sync_seen <= sync_seen + 1;
      if (load === 1'b1) load_seen <= load_seen + 1;
   end
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      complete_run();
   end

   //-------------------------------------------------------------
   // access and compare tasks
   //-------------------------------------------------------------
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      serial_host_model_inst.frame(1'b0, a, d, q);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] q;
      serial_host_model_inst.frame(1'b1, a, 8'h00, q);
      chk(18'(q), 18'(exp));
   endtask
   task automatic drive_pin(input logic v);
      @(posedge clk);
      pin <= v;
      repeat (4) @(posedge clk);
   endtask
   task complete_run;
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   //-------------------------------------------------------------
   // main sequence
   //-------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      pin = 1'b0;
      ref_pin = 1'b1; // analog side only
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (addrs[i]) rd(addrs[i], 8'h00);
      chk(18'({by_pin, p_norm, gpd}), 18'h0_0006);
      wr(7'h12, 8'h5a); // unmapped
      rd(7'h12, 8'h00);
      wr(7'h11, 8'hdf); // reserved bits are not stored
      rd(7'h11, 8'h00);
      wr(7'h11, 8'h20);
      chk(18'(sei), 18'h0_0001);
      rd(7'h11, 8'h20);
      wr(7'h14, 8'h10);
      wr(7'h15, 8'h3c);
      for (int m = 0; m < 8; m++) begin
         wr(7'h16, {3'h0, 3'(m), 2'h2});
         chk(18'(mode), 18'(m));
         chk(pat, 18'h2_3c10);
         chk(18'({p_norm, p_ramp, p_const}), 18'({m == 0, m == 2, m == 3}));
      end
      for (int c = 0; c < 4; c++) begin
         wr(7'h0e, {4'h0, 1'b1, 2'(c), c[0]});
         chk(18'({by_pin, r_int, r_buf, r_dir, cse, dpd}),
             18'({1'b0, c == 0, c == 1, c == 2, c[0], c[0]}));
      end
      wr(7'h0e, 8'h07); // register fields set but pin owns the choice
      chk(18'({by_pin, r_int, r_buf, r_dir, cse, dpd}), 18'h0_0020);
      wr(7'h0e, 8'h00);
      sync_seen = 0;
      drive_pin(1'b1);
      chk(18'(gpd), 18'h0_0001);
      drive_pin(1'b0);
      chk(18'(gpd), 18'h0_0000);
      wr(7'h0e, 8'h80);
      drive_pin(1'b1);
      chk(18'(gpd), 18'h0_0000);
      drive_pin(1'b0);
      chk(18'(sync_seen), 18'h0_0001);
      sync_seen = 0;
      wr(7'h0e, 8'h40); // trigger without enable
      chk(18'(sync_seen), 18'h0_0000);
      wr(7'h0e, 8'h00);
      wr(7'h0e, 8'h20);
      wr(7'h0e, 8'h60);
      chk(18'(sync_seen), 18'h0_0001);
      rd(7'h0e, 8'h60);
      wr(7'h0e, 8'h60); // same level again gives nothing
      chk(18'(sync_seen), 18'h0_0001);
      wr(7'h0e, 8'ha0);
      drive_pin(1'b1);
      drive_pin(1'b0);
      chk(18'(sync_seen), 18'h0_0001);
      wr(7'h11, 8'h20);
      wr(7'h16, 8'h0c);
      wr(7'h0e, 8'h69);
      sync_seen = 0;
      load_seen = 0;
      wr(7'h13, 8'h01);
      rd(7'h13, 8'h01);
      chk(18'(load_seen), 18'h0_0000);
      wr(7'h13, 8'h00);
      chk(18'(load_seen), 18'h0_0001);
      chk(18'(sync_seen), 18'h0_0000);
      foreach (addrs[i]) rd(addrs[i], 8'h00);
      chk(18'({sei, by_pin, p_norm}), 18'h0_0003);
      complete_run();
   end
endmodule

bind adc_sync_ref_pattern_config adc_sync_ref_pattern_config_assertions
   adc_sync_ref_pattern_config_assertions_inst (
   .clk, .reset_n, .sync_powerdown_pin, .global_powerdown, .sync_pulse, .reference_by_pin,
   .reference_internal, .reference_ext_buffered, .reference_ext_direct, .clock_single_ended,
   .diff_clock_powerdown, .single_ended_input, .bit_map_load, .custom_pattern_value,
   .test_pattern_mode, .pattern_normal, .pattern_ramp, .pattern_constant);
`default_nettype wire
